// ===== hw/accb_core.v
// Summary of operation
// - Analog bank port zero returns unsigned 16-bit
// - Input line readable digitally and analog concurrently
// - Output bank returns latched output line states
// - Code 19 updates accumulator with operand
// - Types 0-4 add, sub, mul, div, remainder
// - Types 5-7 and/or/xor; 8 inverts accumulator
// - Type 9 loads operand into accumulator
// - Direct mode replies status 100, echoes operand
// - Code 20 compares, sets flags, ignores type
// - Code 21 jumps only when condition holds
// - Conditions 0-7 test latest compare result
// - Conditions 8-11 test four error flags
// - Standalone port read loads accumulator; direct not
//
// The register offsets and the plain strobed port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "accb_consts.vh"

module accb_core #(
	parameter PC_W = 16
) (
	// Clock and reset.
	input  wire        mclk,
	input  wire        nrst,
	// Command input, one-cycle strobe.
	input  wire        cmd_valid,
	input  wire        cmd_standalone,
	input  wire [7:0]  cmd_instr,
	input  wire [7:0]  cmd_type,
	input  wire [7:0]  cmd_bank,
	input  wire [31:0] cmd_value,
	// Reply.
	output reg         rsp_valid,
	output reg  [7:0]  rsp_status,
	output reg  [31:0] rsp_value,
	// Stored program counter.
	output reg  [PC_W-1:0] pc_value,
	output reg         pc_load,
	output reg         pc_step,
	// Asynchronous pins and sources.
	input  wire        analog_channel_zero,
	input  wire [15:0] adc_result,
	input  wire [5:0]  group_pins,
	input  wire [7:0]  out_latch,
	input  wire        err_timeout,
	input  wire        err_alarm,
	input  wire        err_deviation,
	input  wire        err_position,
	// Register port.
	input  wire [3:0]  reg_addr,
	input  wire [31:0] reg_wdata,
	input  wire        reg_wr,
	input  wire        reg_rd,
	output reg  [31:0] reg_rdata,
	output reg         irq
);

	// Two-stage synchronisers for every asynchronous input.
	// Bit map: [15:0] converter word, [16] analog line level, [22:17] group lines,
	// [30:23] output latch readback, [34:31] error flags with timeout lowest.
	reg [34:0] sync1_reg;
	reg [34:0] sync2_reg;
	wire [34:0] async_in = {err_position, err_deviation, err_alarm, err_timeout,
		out_latch, group_pins, analog_channel_zero, adc_result};

	always @(posedge mclk) begin
		if (!nrst) begin
			sync1_reg <= 35'h000000000;
			sync2_reg <= 35'h000000000;
		end else begin
			sync1_reg <= async_in;
			sync2_reg <= sync1_reg;
		end
	end

	// Synchronised views of the pins.
	wire [15:0] adc_raw = sync2_reg[15:0];
	wire        ain_dig = sync2_reg[16];
	wire [5:0]  grp_s   = sync2_reg[22:17];
	wire [7:0]  outs_s  = sync2_reg[30:23];
	wire [3:0]  errs_s  = sync2_reg[34:31];

	// The converter word crosses as sixteen separate bits, so a sample taken while
	// it changes could mix two results; only a word seen twice in a row is used.
	reg [15:0] adc_prev_reg;
	reg [15:0] adc_hold_reg;
	always @(posedge mclk) begin
		if (!nrst) begin
			adc_prev_reg <= 16'h0000;
			adc_hold_reg <= 16'h0000;
		end else begin
			adc_prev_reg <= adc_raw;
			if (adc_raw == adc_prev_reg) begin
				adc_hold_reg <= adc_raw;
			end
		end
	end

	wire [15:0] adc_s = adc_hold_reg;

	// Architectural state.
	reg signed [31:0] acc_reg;
	reg signed [31:0] acc_next;
	reg        zero_reg;
	reg        greater_reg;
	reg        lower_reg;
	reg [`ACCB_IRQ_WIDTH-1:0] irq_stat_reg;
	reg [`ACCB_IRQ_WIDTH-1:0] irq_mask_reg;

	wire signed [31:0] opnd = cmd_value;

	// Condition evaluation, used by the jump logic.
	function cond_true;
		input [7:0] code;
		input       z;
		input       g;
		input       l;
		input [3:0] e;
		begin
			case (code)
				`ACCB_CC_ZERO:       cond_true = z;
				`ACCB_CC_NONZERO:    cond_true = !z;
				`ACCB_CC_EQUAL:      cond_true = z;
				`ACCB_CC_UNEQUAL:    cond_true = !z;
				`ACCB_CC_GREATER:    cond_true = g;
				`ACCB_CC_GREATER_EQ: cond_true = g | z;
				`ACCB_CC_LOWER:      cond_true = l;
				`ACCB_CC_LOWER_EQ:   cond_true = l | z;
				`ACCB_CC_TIMEOUT:    cond_true = e[0];
				`ACCB_CC_ALARM:      cond_true = e[1];
				`ACCB_CC_DEVIATION:  cond_true = e[2];
				`ACCB_CC_POSITION:   cond_true = e[3];
				default:             cond_true = 1'b0;
			endcase
		end
	endfunction

	wire valid_cc = (cmd_type <= `ACCB_CC_POSITION);

	// Port read value by bank and port number.
	reg [31:0] port_val;
	reg        port_ok;
	always @* begin
		port_val = 32'h00000000;
		port_ok  = 1'b1;
		if (cmd_bank == `ACCB_BANK_ANALOG && cmd_type == 8'h00) begin
			port_val = {16'h0000, adc_s};
		end else if (cmd_bank == `ACCB_BANK_DIGITAL && cmd_type == 8'h00) begin
			port_val = {31'h00000000, ain_dig};
		end else if (cmd_bank == `ACCB_BANK_DIGITAL && cmd_type >= 8'h01 &&
			cmd_type <= 8'h06) begin
			port_val = {31'h00000000, grp_s[cmd_type[2:0] - 3'h1]};
		end else if (cmd_bank == `ACCB_BANK_DIGITAL && cmd_type == 8'hFF) begin
			port_val = {24'h000000, 1'b0, grp_s, ain_dig};
		end else if (cmd_bank == `ACCB_BANK_OUTPUTS && cmd_type <= 8'h07) begin
			port_val = {31'h00000000, outs_s[cmd_type[2:0]]};
		end else begin
			port_ok = 1'b0;
		end
	end

	// Accumulate operation; division by zero leaves the accumulator as is.
	reg op_ok;
	always @* begin
		acc_next = acc_reg;
		op_ok    = 1'b1;
		case (cmd_type)
			`ACCB_OP_ADD:  acc_next = acc_reg + opnd;
			`ACCB_OP_SUB:  acc_next = acc_reg - opnd;
			`ACCB_OP_MUL:  acc_next = acc_reg * opnd;
			`ACCB_OP_DIV:  acc_next = (opnd == 32'sh0) ? acc_reg : acc_reg / opnd;
			`ACCB_OP_REM:  acc_next = (opnd == 32'sh0) ? acc_reg : acc_reg % opnd;
			`ACCB_OP_AND:  acc_next = acc_reg & opnd;
			`ACCB_OP_OR:   acc_next = acc_reg | opnd;
			`ACCB_OP_XOR:  acc_next = acc_reg ^ opnd;
			`ACCB_OP_NOT:  acc_next = ~acc_reg;
			`ACCB_OP_LOAD: acc_next = opnd;
			default:       op_ok = 1'b0;
		endcase
	end

	// Events that set the interrupt status bits.
	wire ev_done  = cmd_valid;
	wire ev_jump  = cmd_valid && cmd_instr == `ACCB_INS_COND_JUMP && cmd_standalone &&
		valid_cc && cond_true(cmd_type, zero_reg, greater_reg, lower_reg, errs_s);

	// Refused commands: unknown instruction, or an unknown type or port.
	wire bad_cmd  = !(cmd_instr == `ACCB_INS_PORT_READ || cmd_instr == `ACCB_INS_ACC_OP ||
		cmd_instr == `ACCB_INS_COMPARE || cmd_instr == `ACCB_INS_COND_JUMP);
	wire ev_error = cmd_valid && (bad_cmd ||
		(cmd_instr == `ACCB_INS_ACC_OP && !op_ok) ||
		(cmd_instr == `ACCB_INS_PORT_READ && !port_ok) ||
		(cmd_instr == `ACCB_INS_COND_JUMP && !valid_cc));

	// Command execution.
	always @(posedge mclk) begin
		if (!nrst) begin
			acc_reg     <= 32'sh00000000;
			zero_reg    <= 1'b0;
			greater_reg <= 1'b0;
			lower_reg   <= 1'b0;
			rsp_valid   <= 1'b0;
			rsp_status  <= 8'h00;
			rsp_value   <= 32'h00000000;
			pc_value    <= {PC_W{1'b0}};
			pc_load     <= 1'b0;
			pc_step     <= 1'b0;
		end else begin
			rsp_valid <= cmd_valid && !cmd_standalone;
			pc_load   <= ev_jump;
			pc_step   <= cmd_valid && cmd_standalone && !ev_jump;
			if (cmd_valid) begin
				rsp_status <= `ACCB_ST_OK;
				rsp_value  <= cmd_value;
				case (cmd_instr)
					`ACCB_INS_ACC_OP: begin
						if (op_ok) begin
							acc_reg <= acc_next;
						end else begin
							rsp_status <= `ACCB_ST_BAD_TYPE;
						end
						rsp_value <= cmd_value;
					end
					`ACCB_INS_COMPARE: begin
						zero_reg    <= (acc_reg == opnd);
						greater_reg <= (acc_reg > opnd);
						lower_reg   <= (acc_reg < opnd);
					end
					`ACCB_INS_COND_JUMP: begin
						// A direct-mode jump is answered but never moves the counter.
						if (ev_jump) begin
							pc_value <= cmd_value[PC_W-1:0];
						end
						if (!valid_cc) begin
							rsp_status <= `ACCB_ST_BAD_TYPE;
						end
					end
					`ACCB_INS_PORT_READ: begin
						if (!port_ok) begin
							rsp_status <= `ACCB_ST_BAD_TYPE;
						end else if (cmd_standalone) begin
							acc_reg <= port_val;
						end
						rsp_value <= port_val;
					end
					default: rsp_status <= `ACCB_ST_BAD_CMD;
				endcase
			end
		end
	end

	// Register writes decoded once for the status and mask registers.
	wire wr_status = reg_wr && (reg_addr == `ACCB_REG_IRQ_STATUS);
	wire wr_mask   = reg_wr && (reg_addr == `ACCB_REG_IRQ_MASK);

	// Interrupt status with write-one-to-clear; a new event wins over the clear.
	wire [`ACCB_IRQ_WIDTH-1:0] ev_vec = {ev_error, ev_jump, ev_done};
	wire [`ACCB_IRQ_WIDTH-1:0] w1c = wr_status ?
		reg_wdata[`ACCB_IRQ_WIDTH-1:0] : {`ACCB_IRQ_WIDTH{1'b0}};

	always @(posedge mclk) begin
		if (!nrst) begin
			irq_stat_reg <= {`ACCB_IRQ_WIDTH{1'b0}};
			irq_mask_reg <= {`ACCB_IRQ_WIDTH{1'b0}};
			irq          <= 1'b0;
		end else begin
			irq_stat_reg <= (irq_stat_reg & ~w1c) | ev_vec;
			if (wr_mask) begin
				irq_mask_reg <= reg_wdata[`ACCB_IRQ_WIDTH-1:0];
			end
			irq <= |(((irq_stat_reg & ~w1c) | ev_vec) & irq_mask_reg);
		end
	end

	// Register read, data in the cycle after the strobe.
	always @(posedge mclk) begin
		if (!nrst) begin
			reg_rdata <= 32'h00000000;
		end else if (reg_rd) begin
			if (reg_addr == `ACCB_REG_IRQ_STATUS) begin
				reg_rdata <= {29'h00000000, irq_stat_reg};
			end else if (reg_addr == `ACCB_REG_IRQ_MASK) begin
				reg_rdata <= {29'h00000000, irq_mask_reg};
			end else if (reg_addr == `ACCB_REG_ACC) begin
				reg_rdata <= acc_reg;
			end else if (reg_addr == `ACCB_REG_FLAGS) begin
				reg_rdata <= {25'h0000000, errs_s, lower_reg, greater_reg, zero_reg};
			end else if (reg_addr == `ACCB_REG_PC) begin
				reg_rdata <= {{(32-PC_W){1'b0}}, pc_value};
			end else begin
				reg_rdata <= 32'h00000000;
			end
		end else begin
			reg_rdata <= 32'h00000000;
		end
	end

endmodule // accb_core

`default_nettype wire

// ===== hw/accb_consts.vh
`ifndef ACCB_CONSTS_VH
`define ACCB_CONSTS_VH

// Instruction codes.
`define ACCB_INS_PORT_READ   8'h0F
`define ACCB_INS_ACC_OP      8'h13
`define ACCB_INS_COMPARE     8'h14
`define ACCB_INS_COND_JUMP   8'h15

// Port banks.
`define ACCB_BANK_DIGITAL    8'h00
`define ACCB_BANK_ANALOG     8'h01
`define ACCB_BANK_OUTPUTS    8'h02

// Accumulate operation type codes.
`define ACCB_OP_ADD          8'h00
`define ACCB_OP_SUB          8'h01
`define ACCB_OP_MUL          8'h02
`define ACCB_OP_DIV          8'h03
`define ACCB_OP_REM          8'h04
`define ACCB_OP_AND          8'h05
`define ACCB_OP_OR           8'h06
`define ACCB_OP_XOR          8'h07
`define ACCB_OP_NOT          8'h08
`define ACCB_OP_LOAD         8'h09

// Jump condition codes.
`define ACCB_CC_ZERO         8'h00
`define ACCB_CC_NONZERO      8'h01
`define ACCB_CC_EQUAL        8'h02
`define ACCB_CC_UNEQUAL      8'h03
`define ACCB_CC_GREATER      8'h04
`define ACCB_CC_GREATER_EQ   8'h05
`define ACCB_CC_LOWER        8'h06
`define ACCB_CC_LOWER_EQ     8'h07
`define ACCB_CC_TIMEOUT      8'h08
`define ACCB_CC_ALARM        8'h09
`define ACCB_CC_DEVIATION    8'h0A
`define ACCB_CC_POSITION     8'h0B

// Reply status codes.
`define ACCB_ST_OK           8'h64
`define ACCB_ST_BAD_CMD      8'h02
`define ACCB_ST_BAD_TYPE     8'h03

// Register offsets.
`define ACCB_REG_IRQ_STATUS  4'h0
`define ACCB_REG_IRQ_MASK    4'h1
`define ACCB_REG_ACC         4'h2
`define ACCB_REG_FLAGS       4'h3
`define ACCB_REG_PC          4'h4

// Interrupt status bit positions.
`define ACCB_IRQ_DONE        0
`define ACCB_IRQ_JUMP        1
`define ACCB_IRQ_ERROR       2
`define ACCB_IRQ_WIDTH       3

`endif

// ===== test/accb_core_properties.sv
`timescale 1ns/1ps
`default_nettype none
`include "accb_consts.vh"
module accb_core_properties #(
	parameter PC_W = 16
) (
	// Clock, reset and command.
	input wire logic            mclk,
	input wire logic            nrst,
	input wire logic            cmd_valid,
	input wire logic            cmd_standalone,
	input wire logic [7:0]      cmd_instr,
	input wire logic [7:0]      cmd_type,
	input wire logic [31:0]     cmd_value,
	input wire logic            err_timeout,
	// Reply and program counter.
	input wire logic            rsp_valid,
	input wire logic [7:0]      rsp_status,
	input wire logic [31:0]     rsp_value,
	input wire logic [PC_W-1:0] pc_value,
	input wire logic            pc_load,
	input wire logic            pc_step
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!nrst);
	// A command from the host, one from the stored program, and a settled timeout flag.
	sequence s_direct; cmd_valid && !cmd_standalone; endsequence
	sequence s_stored; cmd_valid && cmd_standalone; endsequence
	sequence s_tmo_steady; $stable(err_timeout) [*4]; endsequence
	sequence s_acc_op; s_direct ##0 cmd_instr == `ACCB_INS_ACC_OP; endsequence
	chk_reply_direct: assert property (s_direct |=> rsp_valid && !pc_load && !pc_step)
		else $error("direct command reply wrong");
	chk_accumulate_op_cmd_echo: assert property (s_acc_op ##0 cmd_type <= 8'h09 |=>
		rsp_status == `ACCB_ST_OK && rsp_value == $past(cmd_value)) else $error("accumulate_op_cmd reply wrong");
	chk_bad_type: assert property (s_acc_op ##0 cmd_type > 8'h09 |=>
		rsp_status == `ACCB_ST_BAD_TYPE) else $error("bad type not refused");
	chk_stored_once: assert property (s_stored |=> !rsp_valid && (pc_load ^ pc_step))
		else $error("stored command outcome wrong");
	chk_plain_steps: assert property (s_stored ##0 cmd_instr != `ACCB_INS_COND_JUMP |=> pc_step)
		else $error("non-jump did not step");
	chk_jump_target: assert property (pc_load |-> pc_value == $past(cmd_value[PC_W-1:0]))
		else $error("jump target wrong");
	chk_idle_quiet: assert property (!cmd_valid |=> !rsp_valid && !pc_load && !pc_step)
		else $error("output pulse without command");
	chk_timeout_jump: assert property (s_tmo_steady ##0 s_stored ##0
		cmd_instr == `ACCB_INS_COND_JUMP && cmd_type == 8'h08 |=> pc_load == $past(err_timeout))
		else $error("timeout jump wrong");
endmodule // accb_core_properties

bind accb_core accb_core_properties #(.PC_W(PC_W)) chk_u (.mclk, .nrst, .cmd_valid,
	.cmd_standalone, .cmd_instr, .cmd_type, .cmd_value, .err_timeout, .rsp_valid,
	.rsp_status, .rsp_value, .pc_value, .pc_load, .pc_step);
`default_nettype wire

// ===== test/accb_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module accb_host_model (
	// Clock.
	input  wire logic        mclk,
	// Command frame fields.
	output var  logic        cmd_valid,
	output var  logic        cmd_standalone,
	output var  logic [7:0]  cmd_instr,
	output var  logic [7:0]  cmd_type,
	output var  logic [7:0]  cmd_bank,
	output var  logic [31:0] cmd_value
);
	// No frame is pending at start.
	initial begin
		{cmd_valid, cmd_standalone, cmd_instr, cmd_type, cmd_bank, cmd_value} = '0;
	end
	// One frame held for one cycle; fields are scrambled afterwards so stale values never help.
	task automatic send(input logic sa, input logic [7:0] ins, typ, bank, input logic [31:0] val);
		@(posedge mclk);
		{cmd_valid, cmd_standalone, cmd_instr, cmd_type, cmd_bank, cmd_value} <= {1'b1, sa, ins, typ, bank, val};
		@(posedge mclk);
		{cmd_valid, cmd_standalone, cmd_instr, cmd_type, cmd_bank, cmd_value} <= {1'b0, ~sa, ~ins, ~typ, ~bank, ~val};
		#1;
	endtask
endmodule // accb_host_model
`default_nettype wire

// ===== test/accb_core_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "accb_consts.vh"
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin num_errors++; $display("MISMATCH %0t got %h want %h", $time, a, b); end end
module accb_core_tb;
	logic             mclk, nrst, reg_wr, reg_rd, analog_channel_zero, z, g, l;
	logic             err_timeout, err_alarm, err_deviation, err_position;
	logic [3:0]       reg_addr;
	logic [31:0]      reg_wdata, rdv, acc, v;
	logic [15:0]      adc_result;
	logic [7:0]       out_latch, cv;
	logic [5:0]       group_pins;
	int               num_errors, cmp_count, t;
	wire logic        cmd_valid, cmd_standalone, rsp_valid, pc_load, pc_step, irq;
	wire logic [7:0]  cmd_instr, cmd_type, cmd_bank, rsp_status;
	wire logic [31:0] cmd_value, rsp_value, reg_rdata;
	wire logic [15:0] pc_value;
	accb_core dut_u (.mclk, .nrst, .cmd_valid, .cmd_standalone, .cmd_instr, .cmd_type, .cmd_bank,
		.cmd_value, .rsp_valid, .rsp_status, .rsp_value, .pc_value, .pc_load, .pc_step,
		.analog_channel_zero, .adc_result, .group_pins, .out_latch, .err_timeout, .err_alarm,
		.err_deviation, .err_position, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq);
	accb_host_model host_u (.mclk, .cmd_valid, .cmd_standalone, .cmd_instr, .cmd_type, .cmd_bank,
		.cmd_value);
	// The 200 MHz clock.
	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end
	// Register write and read, one strobe cycle each.
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge mclk);
		{reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
		@(posedge mclk);
		reg_wr <= 1'b0;
		#1;
	endtask
	task automatic rd(input logic [3:0] a);
		@(posedge mclk);
		{reg_rd, reg_addr} <= {1'b1, a};
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1 rdv = reg_rdata;
	endtask
	// Expected accumulator after one operation.
	function automatic logic [31:0] f_accumulate_op_cmd(input int op, input logic signed [31:0] a, b);
		case (op)
			0: return a + b;
			1: return a - b;
			2: return a * b;
			3: return a / b;
			4: return a % b;
			5: return a & b;
			6: return a | b;
			7: return a ^ b;
			8: return ~a;
			default: return b;
		endcase
	endfunction
	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	// A hang ends the run as a failure.
	initial begin
		repeat (20000) @(posedge mclk);
		num_errors++;
		print_verdict();
	end
	initial begin
		{nrst, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
		{err_timeout, err_alarm, err_deviation, err_position} = 4'h0;
		{analog_channel_zero, adc_result, out_latch, group_pins} = {1'b1, 16'hA5C3, 8'hB2, 6'h2D};
		repeat (20) @(posedge mclk);
		nrst <= 1'b1;
		// Every operation code in turn, starting with a load.
		acc = 32'h0;
		for (int i = 0; i < 10; i++) begin
			t = (i + 9) % 10;
			v = 32'hFFFFEC78 + i * 32'h000001F5;
			acc = f_accumulate_op_cmd(t, acc, v);
			host_u.send(1'b0, `ACCB_INS_ACC_OP, 8'(t), 8'h00, v);
			`CHK(rsp_value, v)
			rd(`ACCB_REG_ACC);
			`CHK(rdv, acc)
		end
		host_u.send(1'b0, `ACCB_INS_ACC_OP, 8'h0A, 8'h00, 32'h5);
		`CHK(rsp_status, `ACCB_ST_BAD_TYPE)
		rd(`ACCB_REG_ACC);
		`CHK(rdv, acc)
		// An unknown instruction is refused; a division by zero keeps the accumulator.
		host_u.send(1'b0, 8'h30, 8'h00, 8'h00, 32'h5);
		`CHK(rsp_status, `ACCB_ST_BAD_CMD)
		host_u.send(1'b0, `ACCB_INS_ACC_OP, `ACCB_OP_DIV, 8'h00, 32'h0);
		`CHK(rsp_status, `ACCB_ST_OK)
		rd(`ACCB_REG_ACC);
		`CHK(rdv, acc)
		// Port reads in direct mode leave the accumulator alone; stored ones load it.
		host_u.send(1'b0, `ACCB_INS_PORT_READ, 8'h00, `ACCB_BANK_ANALOG, 32'h0);
		`CHK(rsp_value, 32'h0000A5C3)
		host_u.send(1'b0, `ACCB_INS_PORT_READ, 8'h00, `ACCB_BANK_DIGITAL, 32'h0);
		`CHK(rsp_value, 32'h00000001)
		for (t = 1; t < 7; t++) begin
			host_u.send(1'b0, `ACCB_INS_PORT_READ, 8'(t), `ACCB_BANK_DIGITAL, 32'h0);
			`CHK(rsp_value, {31'h0, group_pins[t-1]})
		end
		host_u.send(1'b0, `ACCB_INS_PORT_READ, 8'hFF, `ACCB_BANK_DIGITAL, 32'h0);
		`CHK(rsp_value, {25'h0, group_pins, analog_channel_zero})
		for (t = 0; t < 8; t++) begin
			host_u.send(1'b0, `ACCB_INS_PORT_READ, 8'(t), `ACCB_BANK_OUTPUTS, 32'h0);
			`CHK(rsp_value, {31'h0, out_latch[t]})
		end
		rd(`ACCB_REG_ACC);
		`CHK(rdv, acc)
		host_u.send(1'b1, `ACCB_INS_PORT_READ, 8'h00, `ACCB_BANK_ANALOG, 32'h0);
		rd(`ACCB_REG_ACC);
		`CHK(rdv, 32'h0000A5C3)
		// Three compare outcomes, each tested by all eight conditions.
		host_u.send(1'b0, `ACCB_INS_ACC_OP, `ACCB_OP_LOAD, 8'h00, 32'h5);
		for (int k = 0; k < 3; k++) begin
			v = 32'h7 - 2 * k;
			{z, g, l} = {v == 32'h5, v < 32'h5, v > 32'h5};
			cv = {l | z, l, g | z, g, !z, z, !z, z};
			host_u.send(1'b1, `ACCB_INS_COMPARE, 8'hFF, 8'hFF, v);
			`CHK(pc_step, 1'b1)
			for (t = 0; t < 8; t++) begin
				host_u.send(1'b1, `ACCB_INS_COND_JUMP, 8'(t), 8'h00, 32'h40 + t);
				`CHK(pc_load, cv[t])
			end
		end
		// Each error condition, clear and then raised.
		for (t = 8; t < 12; t++) begin
			for (int b = 0; b < 2; b++) begin
				@(posedge mclk);
				{err_position, err_deviation, err_alarm, err_timeout} <= b ? 4'h1 << (t - 8) : 4'h0;
				repeat (3) @(posedge mclk);
				host_u.send(1'b1, `ACCB_INS_COND_JUMP, 8'(t), 8'h00, 32'h80);
				`CHK(pc_load, b[0])
			end
		end
		host_u.send(1'b0, `ACCB_INS_COND_JUMP, `ACCB_CC_NONZERO, 8'h00, 32'h10);
		`CHK(pc_load, 1'b0)
		// Flags keep the last compare (acc 5 above 3) beside the raised position error.
		rd(`ACCB_REG_FLAGS);
		`CHK(rdv, 32'h00000042)
		rd(`ACCB_REG_PC);
		`CHK(rdv, 32'h00000080)
		// Interrupt raised, cleared and masked; an unmapped address reads zero.
		wr(`ACCB_REG_IRQ_MASK, 32'h1);
		rd(`ACCB_REG_IRQ_MASK);
		`CHK(rdv, 32'h1)
		wr(`ACCB_REG_IRQ_STATUS, 32'h7);
		`CHK(irq, 1'b0)
		host_u.send(1'b0, `ACCB_INS_ACC_OP, `ACCB_OP_LOAD, 8'h00, 32'h1);
		`CHK(irq, 1'b1)
		wr(`ACCB_REG_IRQ_STATUS, 32'h1);
		wr(`ACCB_REG_IRQ_MASK, 32'h0);
		host_u.send(1'b0, `ACCB_INS_ACC_OP, `ACCB_OP_LOAD, 8'h00, 32'h1);
		`CHK(irq, 1'b0)
		rd(`ACCB_REG_IRQ_STATUS);
		`CHK(rdv, 32'h1)
		rd(4'hF);
		`CHK(rdv, 32'h0)
		print_verdict();
	end
endmodule // accb_core_tb
`default_nettype wire
